// File: logic/bpo_defines.vh
`ifndef BPO_DEFINES_VH
`define BPO_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// Timing
`define BPO_CLK_MHZ 250
`define BPO_MS_CYCLES (1000 * `BPO_CLK_MHZ)
`define BPO_T_SETUP_MS 7'h1E
`define BPO_T_VALID_MS 7'h28
`define BPO_T_OFF_MS 7'h10
`define BPO_T_PERIOD_MS 7'h40
`define BPO_T_REQGAP_MS 7'h14

////////////////////////////////////////////////////////////////////////////////
// Widths and limits
`define BPO_MW 20
`define BPO_BCD_MAX 21'h1869F
`define BPO_DD_STEPS 5'h11

////////////////////////////////////////////////////////////////////////////////
// Register map (byte addresses)
`define BPO_ADDR_CTRL 5'h00
`define BPO_ADDR_HI 5'h04
`define BPO_ADDR_LO 5'h08
`define BPO_ADDR_STAT 5'h0C
`define BPO_ADDR_RESULT 5'h10

////////////////////////////////////////////////////////////////////////////////
// Control fields and reset values
`define BPO_CTRL_MODE_LSB 0
`define BPO_CTRL_MODE_MSB 2
`define BPO_CTRL_SBY_BIT 3
`define BPO_CTRL_RST 4'h0
`define BPO_HI_RST 20'h003E8
`define BPO_LO_RST 20'h00000

////////////////////////////////////////////////////////////////////////////////
// Hold modes
`define BPO_MODE_NORMAL 3'h0
`define BPO_MODE_PEAK 3'h1
`define BPO_MODE_BOTTOM 3'h2
`define BPO_MODE_SAMPLE 3'h3
`define BPO_MODE_P2P 3'h4

`endif

// File: logic/bpo_top.v
// Chosen here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`include "bpo_defines.vh"

module bpo_top #(
	parameter MS_CYCLES = `BPO_MS_CYCLES
) (
	input wire sys_clk,
	input wire rst_n,
	input wire [4:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	input wire meas_valid,
	input wire [`BPO_MW-1:0] meas_data,
	output reg meas_ready,
	input wire req_n,
	input wire hold_n,
	input wire max_n,
	input wire min_n,
	input wire clr_n,
	input wire timing_n,
	output reg [19:0] bcd_data,
	output reg bcd_neg,
	output reg bcd_over,
	output reg bcd_valid,
	output reg run_out,
	output reg cmp_hi,
	output reg cmp_pass,
	output reg cmp_lo
);

	localparam [3:0] S_IDLE = 4'h1;
	localparam [3:0] S_SETUP = 4'h2;
	localparam [3:0] S_VALID = 4'h4;
	localparam [3:0] S_GAP = 4'h8;
	localparam [31:0] MS_LAST_W = MS_CYCLES - 1;
	localparam [17:0] MS_LAST = MS_LAST_W[17:0];

	////////////////////////////////////////////////////////////////////////////////
	// Register file

	reg [3:0] ctrl_reg;
	reg signed [`BPO_MW-1:0] hi_reg;
	reg signed [`BPO_MW-1:0] lo_reg;
	reg signed [20:0] val_reg;
	reg [3:0] state_reg;
	reg sb_done_reg;
	reg conv_busy_reg;
	wire [2:0] mode = ctrl_reg[`BPO_CTRL_MODE_MSB:`BPO_CTRL_MODE_LSB];
	wire sby_en = ctrl_reg[`BPO_CTRL_SBY_BIT];
	wire bus_req = avs_read || avs_write;
	wire bus_wr = avs_write && !avs_waitrequest;
	wire ctrl_wr = bus_wr && avs_address == `BPO_ADDR_CTRL;
	reg [31:0] rdata_next;

	always @* begin
		case (avs_address)
			`BPO_ADDR_CTRL: rdata_next = {28'h0000000, ctrl_reg};
			`BPO_ADDR_HI: rdata_next = {{12{hi_reg[`BPO_MW-1]}}, hi_reg};
			`BPO_ADDR_LO: rdata_next = {{12{lo_reg[`BPO_MW-1]}}, lo_reg};
			`BPO_ADDR_STAT: rdata_next = {20'h00000, conv_busy_reg, sb_done_reg, state_reg,
				cmp_hi, cmp_pass, cmp_lo, bcd_valid, bcd_over, bcd_neg};
			`BPO_ADDR_RESULT: rdata_next = {{11{val_reg[20]}}, val_reg};
			default: rdata_next = 32'h00000000;
		endcase
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h00000000;
			ctrl_reg <= `BPO_CTRL_RST;
			hi_reg <= `BPO_HI_RST;
			lo_reg <= `BPO_LO_RST;
		end else begin
			if (bus_req && avs_waitrequest) begin
				avs_waitrequest <= 1'b0;
				avs_readdata <= avs_read ? rdata_next : 32'h00000000;
			end else begin
				avs_waitrequest <= 1'b1;
			end
			if (ctrl_wr) begin
				ctrl_reg <= avs_writedata[3:0];
			end
			if (bus_wr && avs_address == `BPO_ADDR_HI) begin
				hi_reg <= avs_writedata[`BPO_MW-1:0];
			end
			if (bus_wr && avs_address == `BPO_ADDR_LO) begin
				lo_reg <= avs_writedata[`BPO_MW-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Two-entry measurement buffer

	reg [`BPO_MW-1:0] buf_mem [0:1];
	reg buf_wp_reg;
	reg buf_rp_reg;
	reg [1:0] buf_cnt_reg;
	reg upd_reg;
	wire buf_push = meas_valid && meas_ready;
	wire buf_pop = (buf_cnt_reg != 2'h0) && !conv_busy_reg && !upd_reg;
	wire [1:0] buf_cnt_next = buf_cnt_reg + {1'b0, buf_push} - {1'b0, buf_pop};
	wire signed [`BPO_MW-1:0] smp = buf_mem[buf_rp_reg];

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_buf
			always @(posedge sys_clk) begin
				if (buf_push && buf_wp_reg == g) begin
					buf_mem[g] <= meas_data;
				end
			end
		end
	endgenerate

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			buf_wp_reg <= 1'b0;
			buf_rp_reg <= 1'b0;
			buf_cnt_reg <= 2'h0;
			meas_ready <= 1'b0;
		end else begin
			buf_wp_reg <= buf_wp_reg ^ buf_push;
			buf_rp_reg <= buf_rp_reg ^ buf_pop;
			buf_cnt_reg <= buf_cnt_next;
			meas_ready <= buf_cnt_next != 2'h2;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Hold modes
	reg signed [`BPO_MW-1:0] last_reg;
	reg signed [`BPO_MW-1:0] pk_reg;
	reg signed [`BPO_MW-1:0] bt_reg;
	reg signed [`BPO_MW-1:0] sh_reg;
	reg seed_reg;
	reg tim_prev_reg;
	reg signed [20:0] val_next;
	wire tim_on = !timing_n && tim_prev_reg;
	wire restart = tim_on || !clr_n || ctrl_wr;

	always @* begin
		case (mode)
			`BPO_MODE_PEAK: val_next = {pk_reg[`BPO_MW-1], pk_reg};
			`BPO_MODE_BOTTOM: val_next = {bt_reg[`BPO_MW-1], bt_reg};
			`BPO_MODE_SAMPLE: val_next = {sh_reg[`BPO_MW-1], sh_reg};
			`BPO_MODE_P2P: val_next = {pk_reg[`BPO_MW-1], pk_reg} - {bt_reg[`BPO_MW-1], bt_reg};
			default: val_next = {last_reg[`BPO_MW-1], last_reg};
		endcase
		if (!max_n) begin
			val_next = {pk_reg[`BPO_MW-1], pk_reg};
		end else if (!min_n) begin
			val_next = {bt_reg[`BPO_MW-1], bt_reg};
		end
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			last_reg <= {`BPO_MW{1'b0}};
			pk_reg <= {`BPO_MW{1'b0}};
			bt_reg <= {`BPO_MW{1'b0}};
			sh_reg <= {`BPO_MW{1'b0}};
			seed_reg <= 1'b1;
			tim_prev_reg <= 1'b1;
			val_reg <= 21'h000000;
			upd_reg <= 1'b0;
		end else begin
			tim_prev_reg <= timing_n;
			upd_reg <= buf_pop;
			val_reg <= val_next;
			if (tim_on) begin
				sh_reg <= last_reg;
			end
			if (buf_pop) begin
				last_reg <= smp;
				if (seed_reg || smp > pk_reg) begin
					pk_reg <= smp;
				end
				if (seed_reg || smp < bt_reg) begin
					bt_reg <= smp;
				end
			end
			if (restart) begin
				seed_reg <= 1'b1;
			end else if (buf_pop) begin
				seed_reg <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Comparison outputs
	wire over_hi = val_next > $signed({hi_reg[`BPO_MW-1], hi_reg});
	wire under_lo = val_next < $signed({lo_reg[`BPO_MW-1], lo_reg});
	wire in_band = !over_hi && !under_lo;

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmp_hi <= 1'b0;
			cmp_pass <= 1'b0;
			cmp_lo <= 1'b0;
			sb_done_reg <= 1'b0;
		end else begin
			if (upd_reg && in_band) begin
				sb_done_reg <= 1'b1;
			end else if (!clr_n) begin
				sb_done_reg <= 1'b0;
			end
			if (upd_reg) begin
				if (sby_en && !sb_done_reg && !in_band) begin
					cmp_hi <= 1'b0;
					cmp_pass <= 1'b0;
					cmp_lo <= 1'b0;
				end else begin
					cmp_hi <= over_hi;
					cmp_pass <= in_band;
					cmp_lo <= under_lo;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Binary to BCD conversion
	reg [19:0] dd_bcd_reg;
	reg [16:0] dd_bin_reg;
	reg [4:0] dd_cnt_reg;
	reg dd_neg_reg;
	reg dd_over_reg;
	reg [19:0] res_bcd_reg;
	reg res_neg_reg;
	reg res_over_reg;
	wire [19:0] dd_adj;
	wire [20:0] mag = val_next[20] ? (21'h000000 - val_next) : val_next;

	generate
		for (g = 0; g < 5; g = g + 1) begin : g_dig
			assign dd_adj[4*g+3:4*g] = (dd_bcd_reg[4*g+3:4*g] > 4'h4) ?
				(dd_bcd_reg[4*g+3:4*g] + 4'h3) : dd_bcd_reg[4*g+3:4*g];
		end
	endgenerate

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dd_bcd_reg <= 20'h00000;
			dd_bin_reg <= 17'h00000;
			dd_cnt_reg <= 5'h00;
			dd_neg_reg <= 1'b0;
			dd_over_reg <= 1'b0;
			conv_busy_reg <= 1'b0;
			res_bcd_reg <= 20'h00000;
			res_neg_reg <= 1'b0;
			res_over_reg <= 1'b0;
		end else if (conv_busy_reg) begin
			{dd_bcd_reg, dd_bin_reg} <= {dd_adj[18:0], dd_bin_reg, 1'b0};
			dd_cnt_reg <= dd_cnt_reg - 5'h01;
			if (dd_cnt_reg == 5'h01) begin
				conv_busy_reg <= 1'b0;
				res_bcd_reg <= dd_over_reg ? 20'h99999 : {dd_adj[18:0], dd_bin_reg[16]};
				res_neg_reg <= dd_neg_reg;
				res_over_reg <= dd_over_reg;
			end
		end else if (upd_reg) begin
			conv_busy_reg <= 1'b1;
			dd_bcd_reg <= 20'h00000;
			dd_bin_reg <= mag[16:0];
			dd_cnt_reg <= `BPO_DD_STEPS;
			dd_neg_reg <= val_next[20];
			dd_over_reg <= mag > `BPO_BCD_MAX;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// BCD port sequence
	reg [3:0] state_next;
	reg [17:0] tick_cnt_reg;
	reg [6:0] ms_reg;
	reg req_prev_reg;
	reg load;
	reg drop;
	reg blank;
	wire req_rise = !req_n && req_prev_reg;
	wire tick = tick_cnt_reg == MS_LAST;
	wire [6:0] ms_now = ms_reg + {6'h00, tick};

	always @* begin
		state_next = state_reg;
		load = 1'b0;
		drop = 1'b0;
		blank = 1'b0;
		case (state_reg)
			S_IDLE: begin
				if (req_rise) begin
					state_next = S_SETUP;
				end
			end
			S_SETUP: begin
				if (ms_now == `BPO_T_SETUP_MS) begin
					load = 1'b1;
					state_next = S_VALID;
				end
			end
			S_VALID: begin
				if (ms_now == `BPO_T_VALID_MS) begin
					drop = 1'b1;
					state_next = S_GAP;
				end
			end
			S_GAP: begin
				if (req_n && ms_now >= `BPO_T_OFF_MS) begin
					blank = 1'b1;
					state_next = S_IDLE;
				end else if (!req_n && ms_now == `BPO_T_PERIOD_MS - `BPO_T_VALID_MS) begin
					load = 1'b1;
					state_next = S_VALID;
				end
			end
			default: state_next = S_IDLE;
		endcase
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= S_IDLE;
			tick_cnt_reg <= 18'h00000;
			ms_reg <= 7'h00;
			req_prev_reg <= 1'b1;
			run_out <= 1'b0;
			bcd_data <= 20'h00000;
			bcd_neg <= 1'b0;
			bcd_over <= 1'b0;
			bcd_valid <= 1'b0;
		end else begin
			req_prev_reg <= req_n;
			run_out <= 1'b1;
			state_reg <= state_next;
			if (state_next != state_reg) begin
				tick_cnt_reg <= 18'h00000;
				ms_reg <= 7'h00;
			end else begin
				tick_cnt_reg <= tick ? 18'h00000 : tick_cnt_reg + 18'h00001;
				ms_reg <= ms_now;
			end
			if (load) begin
				bcd_valid <= 1'b1;
				if (hold_n || state_reg == S_SETUP) begin
					bcd_data <= res_bcd_reg;
					bcd_neg <= res_neg_reg;
					bcd_over <= res_over_reg;
				end
			end
			if (drop) begin
				bcd_valid <= 1'b0;
			end
			if (blank) begin
				bcd_data <= 20'h00000;
				bcd_neg <= 1'b0;
				bcd_over <= 1'b0;
			end
		end
	end

endmodule // bpo_top

// File: verification/bpo_top_assertions.sv
`timescale 1ns/1ps
module bpo_checker #(
	parameter MS_CYCLES = 20
) (
	input wire sys_clk,
	input wire rst_n,
	input wire req_n,
	input wire hold_n,
	input wire [19:0] bcd_data,
	input wire bcd_valid,
	input wire run_out,
	input wire cmp_hi,
	input wire cmp_pass,
	input wire cmp_lo
);
	reg rq_q;
	reg gap_req;
	reg [31:0] hi_cnt;
	reg [31:0] lo_cnt;
	reg [31:0] rq_cnt;
	reg [19:0] last_data;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////
	// Counters of valid width, gap width and time since request
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rq_q <= 1'b1;
			gap_req <= 1'b0;
			hi_cnt <= 32'h0;
			lo_cnt <= 32'h0;
			rq_cnt <= 32'h0;
			last_data <= 20'h00000;
		end else begin
			rq_q <= req_n;
			gap_req <= bcd_valid ? 1'b1 : (gap_req & !req_n);
			hi_cnt <= bcd_valid ? hi_cnt + 32'h1 : 32'h0;
			lo_cnt <= bcd_valid ? 32'h0 : lo_cnt + 32'h1;
			rq_cnt <= (rq_q && !req_n) ? 32'h1 : rq_cnt + 32'h1;
			last_data <= bcd_valid ? bcd_data : last_data;
		end
	end
	////////////////////////////////////////
	// Properties
	property p_run;
		rst_n && $past(rst_n) |-> run_out;
	endproperty
	a_run: assert property (p_run) else $error("run output low after reset");
	property p_len;
		$fell(bcd_valid) |-> hi_cnt >= 40 * MS_CYCLES - 1 && hi_cnt <= 40 * MS_CYCLES + 1;
	endproperty
	a_len: assert property (p_len) else $error("data valid width wrong");
	property p_rise;
		$rose(bcd_valid) |-> (rq_cnt >= 30 * MS_CYCLES && rq_cnt <= 30 * MS_CYCLES + 3)
			|| (gap_req && lo_cnt >= 24 * MS_CYCLES - 2 && lo_cnt <= 24 * MS_CYCLES + 2);
	endproperty
	a_rise: assert property (p_rise) else $error("data valid rose at wrong time");
	property p_rerise;
		not (!bcd_valid && gap_req && !req_n && lo_cnt == 24 * MS_CYCLES + 3);
	endproperty
	a_rerise: assert property (p_rerise) else $error("no fresh value while requested");
	property p_off;
		!bcd_valid && req_n && lo_cnt == 16 * MS_CYCLES + 3 |-> bcd_data == 20'h00000;
	endproperty
	a_off: assert property (p_off) else $error("data lines not off");
	property p_kept;
		!bcd_valid && lo_cnt == 16 * MS_CYCLES - 3 |-> bcd_data == last_data;
	endproperty
	a_kept: assert property (p_kept) else $error("data lines off too early");
	property p_stable;
		bcd_valid && $past(bcd_valid) |-> $stable(bcd_data);
	endproperty
	a_stable: assert property (p_stable) else $error("data changed while valid");
	property p_hold;
		$rose(bcd_valid) && gap_req && !hold_n && !$past(hold_n) |-> bcd_data == last_data;
	endproperty
	a_hold: assert property (p_hold) else $error("hold did not keep value");
	property p_cmp;
		$onehot0({cmp_hi, cmp_pass, cmp_lo});
	endproperty
	a_cmp: assert property (p_cmp) else $error("comparison outputs overlap");
	c_valid: cover property ($rose(bcd_valid));
	c_cont: cover property ($rose(bcd_valid) && gap_req);
	c_hi: cover property ($rose(cmp_hi));
endmodule // bpo_checker

// File: verification/bpo_ctrl_model.sv
`timescale 1ns/1ps
module bpo_ctrl_model #(
	parameter MS_CYCLES = 20
) (
	input wire sys_clk,
	input wire rst_n,
	input wire bcd_valid,
	input wire [19:0] bcd_data,
	input wire go,
	input wire cont,
	output reg req_n,
	output reg [19:0] got,
	output reg [7:0] seen
);
	reg bv_q;
	reg pend;
	reg [15:0] gap;
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			req_n <= 1'b1;
			got <= 20'h00000;
			seen <= 8'h00;
			bv_q <= 1'b0;
			pend <= 1'b0;
			gap <= 16'h0000;
		end else begin
			bv_q <= bcd_valid;
			gap <= bcd_valid ? 16'h0000 : (gap == 16'hFFFF ? gap : gap + 16'h0001);
			if (go)
				pend <= 1'b1;
			if (bcd_valid && !bv_q) begin
				got <= bcd_data;
				seen <= seen + 8'h01;
				if (!cont)
					req_n <= 1'b1;
			end else if (pend && req_n && !bcd_valid && gap >= 20 * MS_CYCLES) begin
				req_n <= 1'b0;
				pend <= 1'b0;
			end
		end
	end
endmodule // bpo_ctrl_model

// File: verification/test_bpo_top.sv
`timescale 1ns/1ps
module test_bpo_top;
	localparam int MS = 20;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic meas_valid = 1'b0;
	logic [19:0] meas_data = 20'h00000;
	logic meas_ready;
	logic hold_n = 1'b1, max_n = 1'b1, min_n = 1'b1, clr_n = 1'b1, timing_n = 1'b1;
	logic req_n, bcd_neg, bcd_over, bcd_valid, run_out, cmp_hi, cmp_pass, cmp_lo;
	logic [19:0] bcd_data;
	logic [19:0] got;
	logic [7:0] seen;
	logic go = 1'b0;
	logic cont = 1'b0;
	logic stalled = 1'b0;
	logic [31:0] rd;
	int failures = 0;
	int checked = 0;
	always #2 sys_clk = ~sys_clk;
	always @(negedge sys_clk) if (meas_valid && meas_ready === 1'b0) stalled = 1'b1;
	bpo_top #(.MS_CYCLES(MS)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .meas_valid(meas_valid), .meas_data(meas_data),
		.meas_ready(meas_ready), .req_n(req_n), .hold_n(hold_n), .max_n(max_n), .min_n(min_n),
		.clr_n(clr_n), .timing_n(timing_n), .bcd_data(bcd_data), .bcd_neg(bcd_neg), .bcd_over(bcd_over),
		.bcd_valid(bcd_valid), .run_out(run_out), .cmp_hi(cmp_hi), .cmp_pass(cmp_pass), .cmp_lo(cmp_lo));
	bpo_ctrl_model #(.MS_CYCLES(MS)) u_ctrl (.sys_clk(sys_clk), .rst_n(rst_n), .bcd_valid(bcd_valid),
		.bcd_data(bcd_data), .go(go), .cont(cont), .req_n(req_n), .got(got), .seen(seen));
	////////////////////////////////////////
	// Shared tasks
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rdchk(input string nm, input logic [4:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask
	task automatic send(input logic [19:0] v, input logic keep);
		meas_data <= v;
		meas_valid <= 1'b1;
		do @(posedge sys_clk); while (meas_ready !== 1'b1);
		if (!keep) begin
			meas_valid <= 1'b0;
			repeat (40) @(posedge sys_clk);
		end
	endtask
	task automatic send3(input logic [19:0] a, input logic [19:0] b, input logic [19:0] c);
		send(a, 1'b0);
		send(b, 1'b0);
		send(c, 1'b0);
	endtask
	task automatic pulse(input logic t);
		if (t) timing_n <= 1'b0; else clr_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		timing_n <= 1'b1;
		clr_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
	endtask
	task automatic request;
		go <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
	endtask
	task automatic wait_seen(input int n);
		int k;
		k = 0;
		while (seen != n && k < 4000) begin @(posedge sys_clk); k++; end
		chk("seen", n, {24'h0, seen});
	endtask
	task automatic wait_off;
		int k;
		k = 0;
		while (bcd_valid !== 1'b0 && k < 2000) begin @(posedge sys_clk); k++; end
		chk("valid_drop", 32'h0, {31'h0, bcd_valid});
		repeat (16 * MS + 10) @(posedge sys_clk);
	endtask
	function automatic logic [31:0] cmps;
		return {29'h0, cmp_hi, cmp_pass, cmp_lo};
	endfunction
	////////////////////////////////////////
	// Scenarios
	task automatic t_regs;
		rdchk("ctrl", 5'h00, 32'h0);
		rdchk("hi", 5'h04, 32'h3E8);
		rdchk("lo", 5'h08, 32'h0);
		rdchk("unmapped", 5'h14, 32'h0);
		bus(1'b1, 5'h04, 32'h64);
		bus(1'b1, 5'h08, 32'hA);
		rdchk("hi_wr", 5'h04, 32'h64);
	endtask
	task automatic t_modes;
		bus(1'b1, 5'h00, 32'h0);
		send(20'h00032, 1'b0);
		chk("cmp_pass", 32'h2, cmps());
		send(20'h000C8, 1'b0);
		chk("cmp_hi", 32'h4, cmps());
		send(20'hFFFFB, 1'b0);
		chk("cmp_lo", 32'h1, cmps());
		rdchk("normal", 5'h10, 32'hFFFFFFFB);
		bus(1'b1, 5'h00, 32'h1);
		send3(20'h0001E, 20'h00050, 20'h00028);
		rdchk("peak", 5'h10, 32'h50);
		bus(1'b1, 5'h00, 32'h2);
		send3(20'h0001E, 20'h00005, 20'h00028);
		rdchk("bottom", 5'h10, 32'h5);
		bus(1'b1, 5'h00, 32'h4);
		send3(20'h0001E, 20'h00050, 20'h0000A);
		rdchk("p2p", 5'h10, 32'h46);
		max_n <= 1'b0;
		@(posedge sys_clk);
		rdchk("max_sel", 5'h10, 32'h50);
		max_n <= 1'b1;
		min_n <= 1'b0;
		@(posedge sys_clk);
		rdchk("min_sel", 5'h10, 32'hA);
		min_n <= 1'b1;
		bus(1'b1, 5'h00, 32'h3);
		send(20'h00021, 1'b0);
		pulse(1'b1);
		send(20'h0003C, 1'b0);
		rdchk("sample", 5'h10, 32'h21);
	endtask
	task automatic t_standby;
		bus(1'b1, 5'h00, 32'h8);
		pulse(1'b0);
		send(20'h000C8, 1'b0);
		chk("sby_off", 32'h0, cmps());
		send(20'h00032, 1'b0);
		chk("sby_pass", 32'h2, cmps());
		send(20'h000C8, 1'b0);
		chk("sby_hi", 32'h4, cmps());
	endtask
	task automatic t_buffer;
		bus(1'b1, 5'h00, 32'h0);
		send(20'h0000B, 1'b1);
		send(20'h0000C, 1'b1);
		send(20'h0000D, 1'b1);
		send(20'h0007B, 1'b0);
		chk("stall", 32'h1, {31'h0, stalled});
		rdchk("drained", 5'h10, 32'h7B);
	endtask
	task automatic t_single;
		chk("idle_valid", 32'h0, {31'h0, bcd_valid});
		request();
		wait_seen(1);
		chk("single", 32'h00123, {12'h0, got});
		wait_off();
		chk("off", 32'h0, {12'h0, bcd_data});
	endtask
	task automatic t_cont;
		cont <= 1'b1;
		request();
		wait_seen(2);
		send(20'h001C8, 1'b0);
		wait_seen(3);
		chk("fresh", 32'h00456, {12'h0, got});
		hold_n <= 1'b0;
		send(20'h00315, 1'b0);
		wait_seen(4);
		chk("held", 32'h00456, {12'h0, got});
		hold_n <= 1'b1;
		send(20'hCF2C0, 1'b0);
		cont <= 1'b0;
		wait_seen(5);
		chk("over_data", 32'h99999, {12'h0, got});
		chk("over_flags", 32'h3, {30'h0, bcd_neg, bcd_over});
		wait_off();
		chk("cont_off", 32'h0, {12'h0, bcd_data});
		chk("flags_off", 32'h0, {30'h0, bcd_neg, bcd_over});
	endtask
	task automatic wrap_up;
		if (failures == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#200000;
		failures++;
		wrap_up();
	end
	initial begin
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		chk("run", 32'h1, {31'h0, run_out});
		t_regs();
		t_modes();
		t_standby();
		t_buffer();
		t_single();
		t_cont();
		wrap_up();
	end
endmodule // test_bpo_top
bind bpo_top bpo_checker #(.MS_CYCLES(MS_CYCLES)) u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .req_n(req_n),
	.hold_n(hold_n), .bcd_data(bcd_data), .bcd_valid(bcd_valid), .run_out(run_out), .cmp_hi(cmp_hi),
	.cmp_pass(cmp_pass), .cmp_lo(cmp_lo));
